// ### irqc_pkg.sv
// constants, field layout and helpers for the interrupt controller and pin-4 mux
// assumes an 8-bit register address and 16-bit register data on the control port
// Behaviour
// - pin 4 general use needs direction 0, enable 1
// - general mode: bit clock from master clock, input
// - mode enable at 7Ch bit 7, reset 0
// - function select ignored while pin is bit clock
// - function select codes decode; others reserved
// - four sources can raise the interrupt
// - pins are sources only as general inputs
// - flags sticky, cleared by writing one
// - flags readable at any time
// - masked flags still latch, no interrupt
// - interrupt is OR of unmasked flags
// - interrupt holds until unmasked flags cleared
// - per-source polarity inversion before latching
// - per-source selectable debounce before latching
// - status at 7Fh: OR bit 10, flags
// - mask at 80h bits 9,8,5 reset 1
// - loop-lock mask at bit 2, reset 1
// - polarity at 81h, bits reset 0
// - debounce enables at 82h, reset 0
package irqc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PIN4_CTRL = 8'h7c;
    localparam logic [7:0] OFS_STATUS = 8'h7f;
    localparam logic [7:0] OFS_MASK = 8'h80;
    localparam logic [7:0] OFS_POLARITY = 8'h81;
    localparam logic [7:0] OFS_DEBOUNCE = 8'h82;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int POS_MODE_ENA = 7;
    localparam int POS_IRQ_OR = 10;
    localparam int POS_PIN4 = 9;
    localparam int POS_SEQ = 8;
    localparam int POS_PIN1 = 5;
    localparam int POS_LOCK = 2;
    localparam logic RST_MODE_ENA = 1'b0;
    localparam logic [3:0] RST_SEL = 4'h0;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [3:0] RST_MASK = 4'hf;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [3:0] RST_DEBOUNCE = 4'h0;

    // source index inside the 4-bit vectors
    localparam int SRC_LOCK = 0;
    localparam int SRC_PIN1 = 1;
    localparam int SRC_SEQ = 2;
    localparam int SRC_PIN4 = 3;
    localparam int NUM_SRC = 4;

    // ------------------------------------------------------------
    // pin-4 function select codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_INPUT = 4'h0;
    localparam logic [3:0] SEL_CLK_OUT = 4'h1;
    localparam logic [3:0] SEL_DRIVE_LOW = 4'h2;
    localparam logic [3:0] SEL_DRIVE_HIGH = 4'h3;
    localparam logic [3:0] SEL_IRQ_OUT = 4'h4;
    localparam logic [3:0] SEL_LOCK_OUT = 4'h5;
    localparam logic [3:0] SEL_LOOP_CLK = 4'h9;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int DEBOUNCE_CYCLES = 16;
    localparam logic [3:0] MIN_CLK_DIV = 4'h2;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] pack_src(input logic [3:0] v);
        logic [15:0] w;
        w = 16'h0000;
        w[POS_LOCK] = v[SRC_LOCK];
        w[POS_PIN1] = v[SRC_PIN1];
        w[POS_SEQ] = v[SRC_SEQ];
        w[POS_PIN4] = v[SRC_PIN4];
        return w;
    endfunction

    function automatic logic [3:0] unpack_src(input logic [15:0] w);
        logic [3:0] v;
        v = 4'h0;
        v[SRC_LOCK] = w[POS_LOCK];
        v[SRC_PIN1] = w[POS_PIN1];
        v[SRC_SEQ] = w[POS_SEQ];
        v[SRC_PIN4] = w[POS_PIN4];
        return v;
    endfunction

endpackage

// ### irqc_cond_if.sv
// carrier between the controller and its debounce filter
// assumes both ends run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface irqc_cond_if;
    logic [3:0] raw;
    logic [3:0] enable;
    logic [3:0] clean;
    modport ctrl (output raw, output enable, input clean);
    modport filt (input raw, input enable, output clean);
endinterface
`default_nettype wire

// ### irqc_debounce.sv
// per-source debounce filter with bypass
// assumes sources already synchronous to clk_sys
`timescale 1ns/100ps
`default_nettype none
module irqc_debounce #(
    parameter int HOLD = irqc_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    irqc_cond_if.filt cond
);
    localparam int CW = $clog2(HOLD + 1);
    localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD - 1);

    logic [CW-1:0] cnt [irqc_pkg::NUM_SRC];

    // ------------------------------------------------------------
    // filters
    // ------------------------------------------------------------
    for (genvar i = 0; i < irqc_pkg::NUM_SRC; i++) begin : g_src
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                cnt[i] <= '0;
                cond.clean[i] <= 1'b0;
            end else if (!cond.enable[i] || cond.raw[i] == cond.clean[i]) begin
                // bypass follows the level; a matching level restarts the hold
                cnt[i] <= '0;
                if (!cond.enable[i]) begin
                    cond.clean[i] <= cond.raw[i];
                end
            end else if (cnt[i] >= HOLD_LAST) begin
                cnt[i] <= '0;
                cond.clean[i] <= cond.raw[i];
            end else begin
                cnt[i] <= cnt[i] + 1'b1;
            end
        end
    end

    // watched on pin 1 only; all four filters are the same logic
    chk_glitch_blocked: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (HOLD > 1 && cond.enable[irqc_pkg::SRC_PIN1] && !cond.clean[irqc_pkg::SRC_PIN1]
            && $rose(cond.raw[irqc_pkg::SRC_PIN1]))
        |=> !cond.clean[irqc_pkg::SRC_PIN1])
        else $error("one-cycle spike passed the debounce");

endmodule // irqc_debounce
`default_nettype wire

// ### irqc_top.sv
// interrupt controller for four sources plus the pin-4 function multiplexer
// assumes all inputs synchronous to clk_sys; register port is a simple strobe port
`timescale 1ns/100ps
`default_nettype none
module irqc_top #(
    parameter int DEBOUNCE_HOLD = irqc_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic bclk_dir,
    input wire logic aif_bclk_out,
    input wire logic pin4_in,
    output logic pin4_out,
    output logic pin4_oe_n,
    output logic aif_bclk_from_mclk,
    input wire logic pin1_in,
    input wire logic pin1_is_input,
    input wire logic loop_lock,
    input wire logic loop_clock,
    input wire logic sequencer_busy,
    input wire logic [3:0] output_clock_divider,
    output logic irq_out
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic pin4_general_mode_enable;
    logic [3:0] pin4_sel;
    logic [3:0] event_flag;
    logic [3:0] event_mask;
    logic [3:0] event_polarity;
    logic [3:0] event_debounce;

    logic wr_pin4;
    logic wr_status;
    logic wr_mask;
    logic wr_pol;
    logic wr_db;
    logic [3:0] clear_req;
    logic [3:0] set_req;
    logic [3:0] src_gate;
    logic [3:0] src_raw;
    logic pin4_general;
    logic [3:0] eff_sel;
    logic irq_any;

    assign wr_pin4 = reg_wr && reg_addr == irqc_pkg::OFS_PIN4_CTRL;
    assign wr_status = reg_wr && reg_addr == irqc_pkg::OFS_STATUS;
    assign wr_mask = reg_wr && reg_addr == irqc_pkg::OFS_MASK;
    assign wr_pol = reg_wr && reg_addr == irqc_pkg::OFS_POLARITY;
    assign wr_db = reg_wr && reg_addr == irqc_pkg::OFS_DEBOUNCE;

    // ------------------------------------------------------------
    // pin-4 role
    // ------------------------------------------------------------
    // general use needs both the direction and the enable
    assign pin4_general = !bclk_dir && pin4_general_mode_enable;
    // select only counts in general mode
    assign eff_sel = pin4_general ? pin4_sel : irqc_pkg::SEL_INPUT;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin4_general_mode_enable <= irqc_pkg::RST_MODE_ENA;
            pin4_sel <= irqc_pkg::RST_SEL;
        end else if (wr_pin4) begin
            pin4_general_mode_enable <= reg_wdata[irqc_pkg::POS_MODE_ENA];
            pin4_sel <= reg_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // output clock divider
    // ------------------------------------------------------------
    // toggles every divider count, so the pin period is twice the count
    logic [3:0] div_cnt;
    logic [3:0] div_last;
    logic div_tick;
    logic div_clk;

    assign div_last = (output_clock_divider < irqc_pkg::MIN_CLK_DIV)
        ? irqc_pkg::MIN_CLK_DIV - 4'h1 : output_clock_divider - 4'h1;
    assign div_tick = div_cnt >= div_last;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= 4'h0;
        end else if (div_tick) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_clk <= 1'b0;
        end else if (div_tick) begin
            div_clk <= !div_clk;
        end
    end

    // ------------------------------------------------------------
    // pin-4 driver
    // ------------------------------------------------------------
    logic next_pin4_out;
    logic next_pin4_oe_n;

    always_comb begin
        next_pin4_out = 1'b0;
        next_pin4_oe_n = 1'b1;
        if (!pin4_general) begin
            // bit-clock role: drive only as audio master
            next_pin4_out = aif_bclk_out;
            next_pin4_oe_n = !bclk_dir;
        end else begin
            case (eff_sel)
                irqc_pkg::SEL_CLK_OUT: begin
                    next_pin4_out = div_clk;
                    next_pin4_oe_n = 1'b0;
                end
                irqc_pkg::SEL_DRIVE_LOW: begin
                    next_pin4_out = 1'b0;
                    next_pin4_oe_n = 1'b0;
                end
                irqc_pkg::SEL_DRIVE_HIGH: begin
                    next_pin4_out = 1'b1;
                    next_pin4_oe_n = 1'b0;
                end
                irqc_pkg::SEL_IRQ_OUT: begin
                    next_pin4_out = irq_out;
                    next_pin4_oe_n = 1'b0;
                end
                irqc_pkg::SEL_LOCK_OUT: begin
                    next_pin4_out = loop_lock;
                    next_pin4_oe_n = 1'b0;
                end
                irqc_pkg::SEL_LOOP_CLK: begin
                    next_pin4_out = loop_clock;
                    next_pin4_oe_n = 1'b0;
                end
                // input and reserved codes leave the pin floating
                default: begin
                    next_pin4_out = 1'b0;
                    next_pin4_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin4_out <= 1'b0;
            pin4_oe_n <= 1'b1;
            aif_bclk_from_mclk <= 1'b0;
        end else begin
            pin4_out <= next_pin4_out;
            pin4_oe_n <= next_pin4_oe_n;
            aif_bclk_from_mclk <= pin4_general;
        end
    end

    // ------------------------------------------------------------
    // source conditioning
    // ------------------------------------------------------------
    irqc_cond_if cond ();

    // polarity inversion ahead of the filter
    assign src_raw[irqc_pkg::SRC_LOCK] = loop_lock;
    assign src_raw[irqc_pkg::SRC_PIN1] = pin1_in;
    assign src_raw[irqc_pkg::SRC_SEQ] = sequencer_busy;
    assign src_raw[irqc_pkg::SRC_PIN4] = pin4_in;
    assign cond.raw = src_raw ^ event_polarity;
    assign cond.enable = event_debounce;

    irqc_debounce #(
        .HOLD(DEBOUNCE_HOLD)
    ) u_debounce (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .cond(cond)
    );

    // pins only count as sources while they are general inputs
    always_comb begin
        src_gate = 4'hf;
        src_gate[irqc_pkg::SRC_PIN1] = pin1_is_input;
        src_gate[irqc_pkg::SRC_PIN4] = pin4_general && eff_sel == irqc_pkg::SEL_INPUT;
    end

    assign set_req = cond.clean & src_gate;
    assign clear_req = wr_status ? irqc_pkg::unpack_src(reg_wdata) : 4'h0;

    // ------------------------------------------------------------
    // sticky flags, control registers and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_flag <= irqc_pkg::RST_FLAGS;
        end else begin
            // set wins over a simultaneous clear
            event_flag <= (event_flag & ~clear_req) | set_req;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_mask <= irqc_pkg::RST_MASK;
        end else if (wr_mask) begin
            event_mask <= irqc_pkg::unpack_src(reg_wdata);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            event_polarity <= irqc_pkg::RST_POLARITY;
            event_debounce <= irqc_pkg::RST_DEBOUNCE;
        end else begin
            if (wr_pol) begin
                event_polarity <= irqc_pkg::unpack_src(reg_wdata);
            end
            if (wr_db) begin
                event_debounce <= irqc_pkg::unpack_src(reg_wdata);
            end
        end
    end

    assign irq_any = |(event_flag & ~event_mask);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= irq_any;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = 16'h0000;
        case (reg_addr)
            irqc_pkg::OFS_PIN4_CTRL: begin
                next_rdata[irqc_pkg::POS_MODE_ENA] = pin4_general_mode_enable;
                next_rdata[3:0] = pin4_sel;
            end
            irqc_pkg::OFS_STATUS: begin
                // sequencer flag is not meaningful while it runs
                next_rdata = irqc_pkg::pack_src(event_flag);
                next_rdata[irqc_pkg::POS_IRQ_OR] = irq_out;
            end
            irqc_pkg::OFS_MASK: begin
                next_rdata = irqc_pkg::pack_src(event_mask);
            end
            irqc_pkg::OFS_POLARITY: begin
                next_rdata = irqc_pkg::pack_src(event_polarity);
            end
            irqc_pkg::OFS_DEBOUNCE: begin
                next_rdata = irqc_pkg::pack_src(event_debounce);
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_status_write;
        reg_wr && reg_addr == irqc_pkg::OFS_STATUS;
    endsequence

    sequence s_unmasked_pending;
        |(event_flag & ~event_mask);
    endsequence

    chk_bclk_role_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !pin4_general |=> pin4_oe_n == !$past(bclk_dir))
        else $error("pin 4 drive wrong in bit-clock role");

    chk_mclk_source: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!bclk_dir && pin4_general_mode_enable) |=> aif_bclk_from_mclk)
        else $error("bit clock not taken from master clock");

    chk_sel_drive_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (pin4_general && pin4_sel == irqc_pkg::SEL_DRIVE_LOW) |=> (!pin4_oe_n && !pin4_out))
        else $error("drive-low code did not drive low");

    chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (event_flag[irqc_pkg::SRC_SEQ] && !(wr_status && reg_wdata[irqc_pkg::POS_SEQ]))
        |=> event_flag[irqc_pkg::SRC_SEQ])
        else $error("sticky flag lost without a clear");

    chk_resets_again: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (s_status_write and set_req[irqc_pkg::SRC_LOCK]) |=> event_flag[irqc_pkg::SRC_LOCK])
        else $error("active source lost against a clear");

    chk_pin_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!src_gate[irqc_pkg::SRC_PIN4] && !event_flag[irqc_pkg::SRC_PIN4])
        |=> !event_flag[irqc_pkg::SRC_PIN4])
        else $error("pin 4 flagged while not a general input");

    chk_irq_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_unmasked_pending ##1 s_unmasked_pending |-> irq_out ##1 irq_out)
        else $error("interrupt dropped with unmasked flag pending");

    chk_masked_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (event_flag != 4'h0 && (event_flag & ~event_mask) == 4'h0) |=> !irq_out)
        else $error("masked flag raised the interrupt");

endmodule // irqc_top
`default_nettype wire

// ### irqc_top_tb.sv
// self-checking bench for the interrupt controller and the pin-4 function multiplexer
// assumes irqc_pkg and irqc_cond_if compiled first; the bench drives every input itself
`timescale 1ns/100ps
`default_nettype none
module irqc_top_tb;
    // ------------------------------------------------------------
    // signals and instance
    // ------------------------------------------------------------
    localparam int HOLD = 3;
    localparam int LIMIT = 5000;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic bclk_dir = 1'b1;
    logic aif_bclk_out = 1'b0;
    logic pin4_in = 1'b0;
    logic pin4_out;
    logic pin4_oe_n;
    logic aif_bclk_from_mclk;
    logic pin1_in = 1'b0;
    logic pin1_is_input = 1'b1;
    logic loop_lock = 1'b0;
    logic loop_clock = 1'b0;
    logic sequencer_busy = 1'b0;
    logic [3:0] output_clock_divider = 4'h3;
    logic irq_out;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    irqc_top #(.DEBOUNCE_HOLD(HOLD)) u_irqc_top (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_dir(bclk_dir),
        .aif_bclk_out(aif_bclk_out), .pin4_in(pin4_in), .pin4_out(pin4_out),
        .pin4_oe_n(pin4_oe_n), .aif_bclk_from_mclk(aif_bclk_from_mclk), .pin1_in(pin1_in),
        .pin1_is_input(pin1_is_input), .loop_lock(loop_lock), .loop_clock(loop_clock),
        .sequencer_busy(sequencer_busy), .output_clock_divider(output_clock_divider),
        .irq_out(irq_out)
    );

    always #10 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // strobe raised on one falling edge, dropped on the next: never two writes in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        check(what, reg_rdata, exp);
        reg_rd = 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        rd_chk(8'h7c, 16'h0000, "pin4 ctrl reset");
        rd_chk(8'h7f, 16'h0000, "status reset");
        rd_chk(8'h80, 16'h0324, "mask reset");
        rd_chk(8'h81, 16'h0000, "polarity reset");
        rd_chk(8'h82, 16'h0000, "debounce reset");
        wr(8'h83, 16'hffff);
        rd_chk(8'h83, 16'h0000, "unmapped read");
        check("irq after reset", 16'(irq_out), 16'h0000);
    endtask

    task automatic t_mask_latch_clear();
        loop_lock = 1'b1;
        wait_cyc(4);
        check("masked irq", 16'(irq_out), 16'h0000);
        rd_chk(8'h7f, 16'h0004, "masked flag");
        wr(8'h80, 16'h0320);
        wait_cyc(3);
        check("unmasked irq", 16'(irq_out), 16'h0001);
        rd_chk(8'h7f, 16'h0404, "or bit");
        wr(8'h7f, 16'h0004);
        rd_chk(8'h7f, 16'h0404, "clear while active");
        loop_lock = 1'b0;
        wait_cyc(3);
        wr(8'h7f, 16'h0400);
        rd_chk(8'h7f, 16'h0404, "write zero keeps flag");
        wr(8'h7f, 16'h0004);
        wait_cyc(3);
        rd_chk(8'h7f, 16'h0000, "flag cleared");
        check("irq released", 16'(irq_out), 16'h0000);
    endtask

    task automatic t_polarity_two_flags();
        wr(8'h80, 16'h0220);
        wr(8'h81, 16'h0100);
        loop_lock = 1'b1;
        wait_cyc(4);
        rd_chk(8'h7f, 16'h0504, "idle sequencer active");
        loop_lock = 1'b0;
        wr(8'h7f, 16'h0004);
        wait_cyc(3);
        check("irq held by other flag", 16'(irq_out), 16'h0001);
        wr(8'h81, 16'h0000);
        wait_cyc(3);
        wr(8'h7f, 16'h0100);
        wait_cyc(3);
        check("irq after last clear", 16'(irq_out), 16'h0000);
        sequencer_busy = 1'b1;
        wait_cyc(4);
        sequencer_busy = 1'b0;
        wait_cyc(2);
        // flag is only read once the sequencer is idle again
        rd_chk(8'h7f, 16'h0500, "busy sequencer flag");
        wr(8'h7f, 16'h0100);
        wr(8'h80, 16'h0324);
    endtask

    task automatic t_debounce_gate();
        wr(8'h82, 16'h0020);
        wr(8'h80, 16'h0304);
        pin1_in = 1'b1;
        wait_cyc(HOLD - 1);
        pin1_in = 1'b0;
        wait_cyc(HOLD + 3);
        rd_chk(8'h7f, 16'h0000, "short spike dropped");
        pin1_in = 1'b1;
        wait_cyc(HOLD + 3);
        rd_chk(8'h7f, 16'h0420, "held level accepted");
        pin1_in = 1'b0;
        wait_cyc(HOLD + 3);
        wr(8'h7f, 16'h0020);
        pin1_is_input = 1'b0;
        pin1_in = 1'b1;
        wait_cyc(HOLD + 5);
        rd_chk(8'h7f, 16'h0000, "pin1 not input");
        pin1_in = 1'b0;
        pin1_is_input = 1'b1;
        wr(8'h80, 16'h0324);
    endtask

    task automatic t_pin4_mux();
        logic [3:0] sel;
        logic exp_oe_n;
        logic exp_out;
        int rises;
        logic prev;
        aif_bclk_out = 1'b1;
        wait_cyc(2);
        check("bclk master out", 16'({pin4_oe_n, pin4_out}), 16'h0001);
        wr(8'h7c, 16'h0083);
        aif_bclk_out = 1'b0;
        wait_cyc(3);
        check("select ignored as bclk", 16'({pin4_oe_n, pin4_out}), 16'h0000);
        check("bclk from mclk off", 16'(aif_bclk_from_mclk), 16'h0000);
        bclk_dir = 1'b0;
        loop_lock = 1'b1;
        // loop clock held high so code 9 cannot pass as a plain low drive
        loop_clock = 1'b1;
        wait_cyc(3);
        check("bclk from mclk on", 16'(aif_bclk_from_mclk), 16'h0001);
        for (int i = 0; i < 16; i++) begin
            sel = 4'(i);
            if (sel != 4'h1) begin
                exp_oe_n = !(sel inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h9});
                exp_out = (sel == 4'h3) || (sel == 4'h5) || (sel == 4'h9);
                wr(8'h7c, {8'h00, 4'h8, sel});
                wait_cyc(3);
                check("pin4 oe_n per code", 16'(pin4_oe_n), 16'(exp_oe_n));
                if (!exp_oe_n) begin
                    check("pin4 out per code", 16'(pin4_out), 16'(exp_out));
                end
            end
        end
        loop_clock = 1'b0;
        wr(8'h7c, 16'h0081);
        wait_cyc(3);
        rises = 0;
        prev = pin4_out;
        // sampled on falling edges, where the registered pin has settled
        repeat (12) begin
            @(negedge clk_sys);
            if (pin4_out === 1'b1 && prev === 1'b0) begin
                rises++;
            end
            prev = pin4_out;
        end
        check("clock out rises", 16'(rises), 16'h0002);
        check("clock out driven", 16'(pin4_oe_n), 16'h0000);
        loop_lock = 1'b0;
        wr(8'h7c, 16'h0080);
        wr(8'h7f, 16'h0324);
        wr(8'h80, 16'h0124);
        pin4_in = 1'b1;
        wait_cyc(4);
        rd_chk(8'h7f, 16'h0600, "pin4 input source");
        wr(8'h7c, 16'h0083);
        wait_cyc(2);
        wr(8'h7f, 16'h0200);
        wait_cyc(3);
        rd_chk(8'h7f, 16'h0000, "pin4 output not source");
        pin4_in = 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset_values();
        t_mask_latch_clear();
        t_polarity_two_flags();
        t_debounce_gate();
        t_pin4_mux();
        conclude();
    end
endmodule // irqc_top_tb
`default_nettype wire
